// *** dv/asr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// serial host model; sclk moves only inside frames
module asr_host (
  input  wire logic sys_clk,
  input  wire logic sdio_out,
  input  wire logic sdio_oe,
  output logic      serial_chip_select_low,
  output logic      sclk,
  output logic      sdio_in
);
  // idle: deselected, clock low
  initial
  begin
    serial_chip_select_low = 1'b1;
    sclk                   = 1'b0;
    sdio_in                = 1'b0;
  end
  // one frame: instruction then one byte, msb first
  task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wd,
                      output logic [7:0] rq);
    logic [23:0] sh;
    sh = {rd, 2'h0, addr, wd};
    rq = 8'h00;
    @(negedge sys_clk) serial_chip_select_low = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      // released line toggles, so stale data cannot pass
      sdio_in = (rd && i < 8) ? ~sdio_in : sh[i];
      repeat (4) @(negedge sys_clk);
      sclk = 1'b1;
      // read bit only counts while the device drives
      if (i < 8)
        rq[i] = sdio_out & sdio_oe;
      repeat (4) @(negedge sys_clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
    serial_chip_select_low = 1'b1;
    // quiet gap between frames
    repeat (8) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // row: write flag, address, data, expected read
  typedef struct packed {logic wr; logic [12:0] a; logic [7:0] d; logic [7:0] e;} asr_row_t;
  logic        sys_clk;
  logic        rstn;
  logic        csn;
  logic        sclk;
  logic        sdi;
  logic        sdo;
  logic        oe;
  logic        sync_pulse;
  logic        bw_pin;
  logic        dsync;
  logic [3:0]  en;
  logic [11:0] mode;
  logic [23:0] tune;
  logic [7:0]  rq;
  int          err_count;
  int          check_count;
  int          cycles;
  asr_row_t    rows [8] = '{'{1'b0, 13'h0005, 8'h00, 8'h0F}, '{1'b0, 13'h003A, 8'h00, 8'h00},
    '{1'b0, 13'h003C, 8'h00, 8'h00}, '{1'b0, 13'h003E, 8'h00, 8'h1C},
    '{1'b1, 13'h003A, 8'hFF, 8'h03}, '{1'b1, 13'h003C, 8'hFF, 8'h1F},
    '{1'b1, 13'h003E, 8'hDC, 8'h1C}, '{1'b1, 13'h003B, 8'hFF, 8'h00}};
  asr_regs dut (.sys_clk(sys_clk), .rstn(rstn), .serial_chip_select_low(csn), .sclk(sclk),
    .sdio_in(sdi), .sdio_out(sdo), .sdio_oe(oe), .sync_pulse(sync_pulse),
    .bandwidth_select_pin(bw_pin), .divider_sync(dsync),
    .noise_shaping_requantizer_enable(en), .noise_shaping_requantizer_mode(mode),
    .noise_shaping_requantizer_tuning(tune));
  asr_host host (.sys_clk(sys_clk), .sdio_out(sdo), .sdio_oe(oe),
    .serial_chip_select_low(csn), .sclk(sclk), .sdio_in(sdi));
  // 200 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic test_done();
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [23:0] e, logic [23:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic put(logic [12:0] a, logic [7:0] d);
    host.xfer(1'b0, a, d, rq);
  endtask
  // hang guard, well above the run length
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      test_done();
    end
  end
  initial
  begin
    err_count = 0;
    check_count = 0;
    cycles = 0;
    {rstn, sync_pulse, bw_pin} = 3'h0;
    repeat (16) @(negedge sys_clk);
    chk("tuning", 24'h71C71C, tune);
    rstn = 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].wr)
        put(rows[i].a, rows[i].d);
      host.xfer(1'b1, rows[i].a, 8'h00, rq);
      chk("readback", {16'h0, rows[i].e}, {16'h0, rq});
    end
    // sync gating by both enables
    sync_pulse = 1'b1;
    @(negedge sys_clk);
    chk("dsync", 24'h1, {23'h0, dsync});
    put(13'h003A, 8'h02);
    chk("dsync", 24'h0, {23'h0, dsync});
    put(13'h003A, 8'h01);
    chk("dsync", 24'h0, {23'h0, dsync});
    // pin control, then register override
    put(13'h003C, 8'h00);
    chk("en", 24'hF, {20'h0, en});
    chk("mode", 24'h0, {12'h0, mode});
    bw_pin = 1'b1;
    @(negedge sys_clk);
    chk("mode", 24'h249, {12'h0, mode});
    put(13'h003C, 8'h12);
    chk("en", 24'h0, {20'h0, en});
    bw_pin = 1'b0;
    @(negedge sys_clk);
    chk("mode", 24'h249, {12'h0, mode});
    // only channel 0 selected
    put(13'h0005, 8'h01);
    put(13'h003C, 8'h11);
    chk("en", 24'h1, {20'h0, en});
    chk("mode", 24'h248, {12'h0, mode});
    put(13'h003E, 8'h05);
    chk("tuning", 24'h71C705, tune);
    // one tuning step up, channel 0 only
    put(13'h003E, 8'h06);
    chk("tuning", 24'h71C706, tune);
    // mid-run reset: defaults return, pin control resumes
    rstn = 1'b0;
    @(negedge sys_clk);
    chk("tuning", 24'h71C71C, tune);
    chk("en", 24'h0, {20'h0, en});
    chk("dsync", 24'h0, {23'h0, dsync});
    rstn = 1'b1;
    @(negedge sys_clk);
    chk("en", 24'hF, {20'h0, en});
    chk("mode", 24'h0, {12'h0, mode});
    host.xfer(1'b1, 13'h0005, 8'h00, rq);
    chk("readback", 24'h00000F, {16'h0, rq});
    test_done();
  end
endmodule
`default_nettype wire

// *** rtl/asr_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module asr_regs (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        serial_chip_select_low,
  input  wire logic        sclk,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe,
  input  wire logic        sync_pulse,
  input  wire logic        bandwidth_select_pin,
  output logic             divider_sync,
  output logic [3:0]       noise_shaping_requantizer_enable,
  output logic [11:0]      noise_shaping_requantizer_mode,
  output logic [23:0]      noise_shaping_requantizer_tuning
);
  // whole block state in one record
  typedef struct packed {
    logic             sclk_q;    // previous serial clock level
    logic [4:0]       cnt;       // bit position in frame
    logic [15:0]      shreg;     // incoming shift register
    logic             rd;        // frame is a read
    logic [12:0]      addr;      // current register address
    logic [7:0]       dout;      // outgoing read byte
    logic             oe;        // driving the data pin
    logic [3:0]       chan;      // channel select mask
    logic [1:0]       sync_ctl;  // divider and master enables
    logic [3:0][4:0]  ctl;       // per-channel control bits
    logic [3:0][5:0]  tune;      // per-channel tuning words
    logic             sync_o;    // gated sync to divider
    logic [3:0]       en_o;      // effective requantizer enables
    logic [3:0][2:0]  mode_o;    // effective bandwidth modes
  } asr_state_t;

  asr_state_t st;
  asr_state_t next_st;

  // read mux; a local register reads from the lowest selected channel
  function automatic logic [7:0] asr_read(input logic [12:0] a, input asr_state_t s);
    logic [1:0] c;
    c = 2'h0;
    for (int i = asr_pkg::NUM_CHAN - 1; i >= 0; i--)
      if (s.chan[i]) c = 2'(i);
    if (a == asr_pkg::ADDR_CHAN_INDEX)
      asr_read = {4'h0, s.chan};
    else if (a == asr_pkg::ADDR_SYNC_CTL)
      asr_read = {6'h00, s.sync_ctl};
    else if (a == asr_pkg::ADDR_REQ_CTL)
      asr_read = {3'h0, s.ctl[c]};
    else if (a == asr_pkg::ADDR_REQ_TUNE)
      asr_read = {2'h0, s.tune[c]};
    else
      asr_read = 8'h00;
  endfunction

  logic rise;  // serial clock rising edge
  logic fall;  // serial clock falling edge
  assign rise = sclk & ~st.sclk_q;
  assign fall = ~sclk & st.sclk_q;

  // next state: serial framing, register writes, output mapping
  always_comb
  begin
    logic [15:0] sh;
    logic [7:0]  wd;
    sh = {st.shreg[14:0], sdio_in};
    wd = sh[7:0];
    next_st = st;
    next_st.sclk_q = sclk;
    if (serial_chip_select_low)
    begin
      // frame idle: port released and counters cleared
      next_st.cnt = 5'h00;
      next_st.oe = 1'b0;
    end
    else if (rise)
    begin
      next_st.shreg = sh;
      next_st.cnt = st.cnt + 5'h01;
      if (st.cnt == asr_pkg::CNT_INSTR_LAST)
      begin
        // instruction done: rw flag, then 13-bit address
        next_st.rd = sh[15];
        next_st.addr = sh[12:0];
        next_st.dout = asr_read(sh[12:0], st);
        next_st.oe = sh[15];
      end
      else if (st.cnt == asr_pkg::CNT_DATA_LAST)
      begin
        // streaming continues at the next lower address
        next_st.cnt = asr_pkg::CNT_DATA_FIRST;
        next_st.addr = st.addr - 13'h0001;
        next_st.dout = asr_read(st.addr - 13'h0001, st);
        if (!st.rd)
        begin
          if (st.addr == asr_pkg::ADDR_CHAN_INDEX)
            next_st.chan = wd[3:0];
          else if (st.addr == asr_pkg::ADDR_SYNC_CTL)
            next_st.sync_ctl = wd[1:0];
          for (int i = 0; i < asr_pkg::NUM_CHAN; i++)
          begin
            if (st.chan[i] && st.addr == asr_pkg::ADDR_REQ_CTL)
              next_st.ctl[i] = wd[4:0];
            if (st.chan[i] && st.addr == asr_pkg::ADDR_REQ_TUNE)
              next_st.tune[i] = wd[5:0];
          end
        end
      end
    end
    else if (fall && st.oe && st.cnt != asr_pkg::CNT_DATA_FIRST)
      next_st.dout = {st.dout[6:0], 1'b0};
    // sync gating: both enables required
    next_st.sync_o = sync_pulse & st.sync_ctl[asr_pkg::SYNC_DIVIDER_BIT]
                   & st.sync_ctl[asr_pkg::SYNC_MASTER_BIT];
    // override chooses register fields or the pin per channel
    for (int i = 0; i < asr_pkg::NUM_CHAN; i++)
    begin
      if (st.ctl[i][asr_pkg::REQ_OVR_BIT])
      begin
        next_st.en_o[i] = st.ctl[i][asr_pkg::REQ_EN_BIT];
        next_st.mode_o[i] = st.ctl[i][asr_pkg::REQ_MODE_LSB +: 3];
      end
      else
      begin
        next_st.en_o[i] = 1'b1;
        next_st.mode_o[i] = bandwidth_select_pin ? asr_pkg::MODE_BW33
                                                 : asr_pkg::MODE_BW22;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
      st.chan <= asr_pkg::RST_CHAN_INDEX;
      st.sync_ctl <= asr_pkg::RST_SYNC_CTL[1:0];
      for (int i = 0; i < asr_pkg::NUM_CHAN; i++)
      begin
        st.ctl[i] <= asr_pkg::RST_REQ_CTL[4:0];
        st.tune[i] <= asr_pkg::RST_REQ_TUNE[5:0];
      end
    end
    else
      st <= next_st;
  end

  // outputs straight from flops; tuning word is the edge step count
  assign sdio_out = st.dout[7];
  assign sdio_oe = st.oe;
  assign divider_sync = st.sync_o;
  assign noise_shaping_requantizer_enable = st.en_o;
  assign noise_shaping_requantizer_mode = st.mode_o;
  assign noise_shaping_requantizer_tuning = st.tune;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_sync_armed;
    st.sync_ctl == 2'h3 && sync_pulse;
  endsequence
  property p_sync_pass;
    s_sync_armed |=> divider_sync;
  endproperty
  a_sync_pass: assert property (p_sync_pass) else $error("sync not passed");
  property p_sync_master;
    !st.sync_ctl[0] |=> !divider_sync;
  endproperty
  a_sync_master: assert property (p_sync_master) else $error("sync with master off");
  property p_pin_ctl;
    !st.ctl[0][4] |=> noise_shaping_requantizer_mode[2:0] == {2'h0, $past(bandwidth_select_pin)};
  endproperty
  a_pin_ctl: assert property (p_pin_ctl) else $error("pin not followed");
  property p_unsel;
    !st.chan[1] |=> $stable(st.ctl[1]) && $stable(st.tune[1]);
  endproperty
  a_unsel: assert property (p_unsel) else $error("unselected channel changed");
  property p_mode;
    st.ctl[2][4] |=> noise_shaping_requantizer_mode[8:6] == $past(st.ctl[2][3:1]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode field not applied");
  property p_enable;
    st.ctl[3][4] |=> noise_shaping_requantizer_enable[3] == $past(st.ctl[3][0]);
  endproperty
  a_enable: assert property (p_enable) else $error("enable bit not applied");
  // last data rise of a write frame aimed at channel 0 tuning
  sequence s_tune_write;
    rise && !serial_chip_select_low && st.cnt == asr_pkg::CNT_DATA_LAST && !st.rd
      && st.addr == asr_pkg::ADDR_REQ_TUNE && st.chan[0];
  endsequence
  property p_tune;
    s_tune_write |=> noise_shaping_requantizer_tuning[5:0] == {$past(st.shreg[4:0]), $past(sdio_in)};
  endproperty
  a_tune: assert property (p_tune) else $error("tuning word mismatch");
  // read instruction for the sync register just completed
  property p_reserved;
    rise && !serial_chip_select_low && st.cnt == asr_pkg::CNT_INSTR_LAST && st.shreg[14]
      && {st.shreg[11:0], sdio_in} == asr_pkg::ADDR_SYNC_CTL
    |=> st.dout[7:2] == 6'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
  // last data rise of a write frame aimed at the sync register
  sequence s_sync_write;
    rise && !serial_chip_select_low && st.cnt == asr_pkg::CNT_DATA_LAST && !st.rd
      && st.addr == asr_pkg::ADDR_SYNC_CTL;
  endsequence
  property p_sync_write;
    s_sync_write |=> st.sync_ctl == {$past(st.shreg[0]), $past(sdio_in)};
  endproperty
  a_sync_write: assert property (p_sync_write) else $error("sync write not stored");
endmodule
`default_nettype wire

// *** shared/asr_pkg.sv ***
`default_nettype none
package asr_pkg;
  // register offsets on the serial port
  localparam logic [12:0] ADDR_CHAN_INDEX = 13'h0005;
  localparam logic [12:0] ADDR_SYNC_CTL   = 13'h003A;
  localparam logic [12:0] ADDR_REQ_CTL    = 13'h003C;
  localparam logic [12:0] ADDR_REQ_TUNE   = 13'h003E;
  // field positions
  localparam int SYNC_MASTER_BIT  = 0;
  localparam int SYNC_DIVIDER_BIT = 1;
  localparam int REQ_EN_BIT       = 0;
  localparam int REQ_MODE_LSB     = 1;
  localparam int REQ_OVR_BIT      = 4;
  // values after reset
  localparam logic [7:0] RST_SYNC_CTL   = 8'h00;
  localparam logic [7:0] RST_REQ_CTL    = 8'h00;
  localparam logic [7:0] RST_REQ_TUNE   = 8'h1C;
  localparam logic [3:0] RST_CHAN_INDEX = 4'hF;
  // bandwidth mode codes
  localparam logic [2:0] MODE_BW22 = 3'h0;
  localparam logic [2:0] MODE_BW33 = 3'h1;
  // serial frame bit counts
  localparam logic [4:0] CNT_INSTR_LAST = 5'h0F;
  localparam logic [4:0] CNT_DATA_FIRST = 5'h10;
  localparam logic [4:0] CNT_DATA_LAST  = 5'h17;
  localparam int NUM_CHAN = 4;
endpackage
`default_nettype wire
